//--- verilog/cap_top.sv
// Card side answer to reset and speed negotiation with APB registers.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cap_regs.svh"
module cap_top (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic card_clk,
	input wire logic card_rst_b,
	input wire logic io_in,
	output logic io_out,
	output logic io_oe
);
	cap_pkg::cap_state_e state_reg;
	cap_pkg::cap_fd_e fd_reg;
	cap_pkg::cap_fd_e fd_next;
	cap_pkg::cap_char_s tx_reg;
	cap_pkg::cap_char_s rx_char;
	logic [7:0] atr_mem [0:32];
	logic [7:0] rsp_reg [0:3];
	logic [5:0] atr_len_reg;
	logic [5:0] atr_wptr_reg;
	logic [5:0] byte_idx_reg;
	logic [2:0] rsp_len_reg;
	logic enable_reg;
	logic enh_reg;
	logic d16_reg;
	logic card_clk_d_reg;
	logic clk_rise;
	logic [15:0] wait_cnt_reg;
	logic [2:0] pps_cnt_reg;
	logic [7:0] pps0_reg;
	logic [7:0] pps1_reg;
	logic [7:0] xor_reg;
	logic [3:0] y_reg;
	logic [2:0] grp_reg;
	logic t15_reg;
	logic [7:0] ta1_reg;
	logic ta1_seen_reg;
	logic [1:0] clock_stop_indicator_reg;
	logic [5:0] voltage_class_indicator_reg;
	logic glob_seen_reg;
	logic [7:0] rx_hold_reg;
	logic rx_valid_reg;
	logic [7:0] tx_hold_reg;
	logic tx_pend_reg;
	logic pps_ok_reg;
	logic pps_bad_reg;
	logic tx_fail_reg;
	logic io_busy;
	logic io_restart;
	logic io_rst_b;
	logic io_fail;
	logic tick_mid;
	logic tick_edge;
	logic [8:0] etu_len;
	logic io_idle;
	logic issue;
	logic [7:0] cur_byte;
	logic [2:0] after_len;
	logic pps_last;
	logic acc_8;
	logic acc_16;
	logic acc;
	logic [7:0] rsp_pps0;
	logic [7:0] rsp_pck;
	logic acc_phase;
	logic wr;
	logic rd_rx;
	logic mapped;
	logic [31:0] rdata;
	logic [31:0] status;

	assign clk_rise = card_clk && !card_clk_d_reg;
	assign io_out = 1'h0;
	assign io_idle = !io_busy && !tx_reg.valid;
	// Card reset or disable silences the transceiver at once.
	assign io_rst_b = rst_b && card_rst_b && enable_reg;

	always_comb begin
		case (fd_reg)
			cap_pkg::FD_512_8: etu_len = 9'(`CAP_F_ENH / `CAP_D_ENH);
			cap_pkg::FD_512_16: etu_len = 9'(`CAP_F_ENH / `CAP_D_FAST);
			default: etu_len = 9'(`CAP_F_DEF / `CAP_D_DEF);
		endcase
	end

	cap_etu_gen u_etu (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_rise(clk_rise),
		.restart(io_restart),
		.etu_len(etu_len),
		.tick_mid(tick_mid),
		.tick_edge(tick_edge)
	);

	cap_char_io u_io (
		.sys_clk(sys_clk),
		.rst_b(io_rst_b),
		.io_in(io_in),
		.tick_mid(tick_mid),
		.tick_edge(tick_edge),
		.tx_in(tx_reg),
		.restart(io_restart),
		.io_oe(io_oe),
		.rx_out(rx_char),
		.tx_fail(io_fail),
		.busy(io_busy)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			card_clk_d_reg <= 1'h0;
		end else begin
			card_clk_d_reg <= card_clk;
		end
	end

	// One waiting character is handed to the transceiver only while it is idle.
	always_comb begin
		issue = 1'h0;
		cur_byte = tx_hold_reg;
		case (state_reg)
			cap_pkg::ST_ATR_SEND: begin
				issue = io_idle && (byte_idx_reg < atr_len_reg);
				cur_byte = atr_mem[byte_idx_reg];
			end
			cap_pkg::ST_PPS_TX: begin
				issue = io_idle && ({3'h0, rsp_len_reg} > byte_idx_reg);
				cur_byte = rsp_reg[byte_idx_reg[1:0]];
			end
			cap_pkg::ST_SESSION: begin
				issue = io_idle && tx_pend_reg;
			end
			default: begin
				issue = 1'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			tx_reg <= '0;
		end else begin
			tx_reg <= {issue, cur_byte};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_reg == cap_pkg::ST_RESET ||
			state_reg == cap_pkg::ST_PPS_RX) begin
			byte_idx_reg <= 6'h00;
		end else if (issue && state_reg != cap_pkg::ST_SESSION) begin
			byte_idx_reg <= byte_idx_reg + 6'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_reg != cap_pkg::ST_ATR_WAIT) begin
			wait_cnt_reg <= 16'h0000;
		end else if (clk_rise) begin
			wait_cnt_reg <= wait_cnt_reg + 16'h0001;
		end
	end

	// Response decision: unsupported or default requests get default values.
	assign after_len = 3'h2 + {2'h0, pps0_reg[4]} + {2'h0, pps0_reg[5]} +
		{2'h0, pps0_reg[6]};
	assign pps_last = rx_char.valid && (pps_cnt_reg != 3'h0) &&
		(pps_cnt_reg == after_len - 3'h1);
	assign acc_8 = pps0_reg[4] && enh_reg && pps1_reg[7:4] == `CAP_FI_512 &&
		pps1_reg[3:0] == `CAP_DI_8;
	assign acc_16 = pps0_reg[4] && enh_reg && d16_reg &&
		pps1_reg[7:4] == `CAP_FI_512 && pps1_reg[3:0] == `CAP_DI_16;
	assign acc = acc_8 || acc_16;
	assign rsp_pps0 = {3'h0, acc, 4'h0};
	assign rsp_pck = `CAP_PPSS ^ rsp_pps0 ^ (acc ? pps1_reg : 8'h00);
	assign fd_next = acc_16 ? cap_pkg::FD_512_16 :
		(acc_8 ? cap_pkg::FD_512_8 : cap_pkg::FD_DEFAULT);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_reg <= cap_pkg::ST_RESET;
		end else if (!card_rst_b || !enable_reg) begin
			state_reg <= cap_pkg::ST_RESET;
		end else begin
			case (state_reg)
				cap_pkg::ST_RESET: begin
					state_reg <= cap_pkg::ST_ATR_WAIT;
				end
				cap_pkg::ST_ATR_WAIT: begin
					if (wait_cnt_reg == `CAP_ATR_DELAY) begin
						state_reg <= cap_pkg::ST_ATR_SEND;
					end
				end
				cap_pkg::ST_ATR_SEND: begin
					if (byte_idx_reg >= atr_len_reg && io_idle) begin
						state_reg <= cap_pkg::ST_LISTEN;
					end
				end
				cap_pkg::ST_LISTEN: begin
					if (rx_char.valid) begin
						state_reg <= (rx_char.data == `CAP_PPSS) ?
							cap_pkg::ST_PPS_RX : cap_pkg::ST_SESSION;
					end
				end
				cap_pkg::ST_PPS_RX: begin
					if (pps_last) begin
						state_reg <= ((xor_reg ^ rx_char.data) == 8'h00) ?
							cap_pkg::ST_PPS_TX : cap_pkg::ST_SESSION;
					end
				end
				cap_pkg::ST_PPS_TX: begin
					if ({3'h0, rsp_len_reg} <= byte_idx_reg && io_idle) begin
						state_reg <= cap_pkg::ST_SESSION;
					end
				end
				cap_pkg::ST_SESSION: begin
					state_reg <= cap_pkg::ST_SESSION;
				end
				default: begin
					state_reg <= cap_pkg::ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_reg == cap_pkg::ST_LISTEN) begin
			pps_cnt_reg <= 3'h0;
			pps0_reg <= 8'h00;
			pps1_reg <= 8'h00;
			xor_reg <= `CAP_PPSS;
		end else if (state_reg == cap_pkg::ST_PPS_RX && rx_char.valid) begin
			pps_cnt_reg <= pps_cnt_reg + 3'h1;
			xor_reg <= xor_reg ^ rx_char.data;
			if (pps_cnt_reg == 3'h0) begin
				pps0_reg <= rx_char.data;
			end
			if (pps_cnt_reg == 3'h1 && pps0_reg[4]) begin
				pps1_reg <= rx_char.data;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rsp_reg[0] <= `CAP_PPSS;
			rsp_reg[1] <= 8'h00;
			rsp_reg[2] <= 8'h00;
			rsp_reg[3] <= 8'h00;
			rsp_len_reg <= 3'h3;
		end else if (state_reg == cap_pkg::ST_PPS_RX) begin
			rsp_reg[0] <= `CAP_PPSS;
			rsp_reg[1] <= rsp_pps0;
			rsp_reg[2] <= acc ? pps1_reg : rsp_pck;
			rsp_reg[3] <= rsp_pck;
			rsp_len_reg <= acc ? 3'h4 : 3'h3;
		end
	end

	// The new pair applies only once the whole response has gone out.
	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_reg == cap_pkg::ST_RESET) begin
			fd_reg <= cap_pkg::FD_DEFAULT;
		end else if (state_reg == cap_pkg::ST_PPS_TX &&
			{3'h0, rsp_len_reg} <= byte_idx_reg && io_idle) begin
			fd_reg <= (rsp_len_reg == 3'h4) ? fd_next : cap_pkg::FD_DEFAULT;
		end
	end

	// Tracks the interface characters of the answer as they are sent.
	always_ff @(posedge sys_clk) begin
		if (!rst_b || state_reg == cap_pkg::ST_ATR_WAIT) begin
			y_reg <= 4'h0;
			grp_reg <= 3'h1;
			t15_reg <= 1'h0;
			ta1_reg <= 8'h00;
			ta1_seen_reg <= 1'h0;
			clock_stop_indicator_reg <= 2'h0;
			voltage_class_indicator_reg <= 6'h00;
			glob_seen_reg <= 1'h0;
		end else if (issue && state_reg == cap_pkg::ST_ATR_SEND) begin
			if (byte_idx_reg == 6'h01) begin
				y_reg <= cur_byte[7:4];
			end else if (byte_idx_reg > 6'h01 && y_reg[0]) begin
				y_reg[0] <= 1'h0;
				if (grp_reg == 3'h1) begin
					ta1_reg <= cur_byte;
					ta1_seen_reg <= 1'h1;
				end else if (t15_reg) begin
					clock_stop_indicator_reg <= cur_byte[7:6];
					voltage_class_indicator_reg <= cur_byte[5:0];
					glob_seen_reg <= 1'h1;
				end
			end else if (byte_idx_reg > 6'h01 && y_reg[1]) begin
				y_reg[1] <= 1'h0;
			end else if (byte_idx_reg > 6'h01 && y_reg[2]) begin
				y_reg[2] <= 1'h0;
			end else if (byte_idx_reg > 6'h01 && y_reg[3]) begin
				y_reg <= cur_byte[7:4];
				t15_reg <= cur_byte[3:0] == `CAP_TD_T15;
				grp_reg <= grp_reg + 3'h1;
			end
		end
	end

	assign acc_phase = psel && penable && pready;
	assign wr = acc_phase && pwrite;
	assign rd_rx = acc_phase && !pwrite && paddr == `CAP_OFF_RX;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			enable_reg <= 1'(`CAP_CTRL_RST >> `CAP_CTRL_EN);
			enh_reg <= 1'h0;
			d16_reg <= 1'h0;
		end else if (wr && paddr == `CAP_OFF_CTRL) begin
			enable_reg <= pwdata[`CAP_CTRL_EN];
			enh_reg <= pwdata[`CAP_CTRL_ENH];
			d16_reg <= pwdata[`CAP_CTRL_D16];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			atr_len_reg <= 6'h00;
			atr_wptr_reg <= 6'h00;
		end else if (wr && paddr == `CAP_OFF_ATR_LEN) begin
			atr_len_reg <= (pwdata[5:0] > `CAP_ATR_MAX) ? `CAP_ATR_MAX :
				pwdata[5:0];
			atr_wptr_reg <= 6'h00;
		end else if (wr && paddr == `CAP_OFF_ATR_DATA &&
			atr_wptr_reg < `CAP_ATR_MAX) begin
			atr_wptr_reg <= atr_wptr_reg + 6'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wr && paddr == `CAP_OFF_ATR_DATA && atr_wptr_reg < `CAP_ATR_MAX) begin
			atr_mem[atr_wptr_reg] <= pwdata[7:0];
		end
	end

	// A character arriving during the read that empties the holder wins.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rx_hold_reg <= 8'h00;
			rx_valid_reg <= 1'h0;
		end else if (rx_char.valid && (state_reg == cap_pkg::ST_SESSION ||
			(state_reg == cap_pkg::ST_LISTEN && rx_char.data != `CAP_PPSS))) begin
			rx_hold_reg <= rx_char.data;
			rx_valid_reg <= 1'h1;
		end else if (rd_rx) begin
			rx_valid_reg <= 1'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			tx_hold_reg <= 8'h00;
			tx_pend_reg <= 1'h0;
		end else if (issue && state_reg == cap_pkg::ST_SESSION) begin
			tx_pend_reg <= 1'h0;
		end else if (wr && paddr == `CAP_OFF_TX && !tx_pend_reg &&
			state_reg == cap_pkg::ST_SESSION) begin
			tx_hold_reg <= pwdata[7:0];
			tx_pend_reg <= 1'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pps_ok_reg <= 1'h0;
			pps_bad_reg <= 1'h0;
			tx_fail_reg <= 1'h0;
		end else begin
			if (state_reg == cap_pkg::ST_PPS_RX && pps_last &&
				(xor_reg ^ rx_char.data) == 8'h00) begin
				pps_ok_reg <= 1'h1;
			end else if (wr && paddr == `CAP_OFF_STATUS &&
				pwdata[`CAP_ST_PPS_OK]) begin
				pps_ok_reg <= 1'h0;
			end
			if (state_reg == cap_pkg::ST_PPS_RX && pps_last &&
				(xor_reg ^ rx_char.data) != 8'h00) begin
				pps_bad_reg <= 1'h1;
			end else if (wr && paddr == `CAP_OFF_STATUS &&
				pwdata[`CAP_ST_PPS_BAD]) begin
				pps_bad_reg <= 1'h0;
			end
			if (io_fail) begin
				tx_fail_reg <= 1'h1;
			end else if (wr && paddr == `CAP_OFF_STATUS &&
				pwdata[`CAP_ST_TX_FAIL]) begin
				tx_fail_reg <= 1'h0;
			end
		end
	end

	assign status = {7'h00, ta1_seen_reg, ta1_reg, 5'h00, tx_fail_reg,
		pps_bad_reg, pps_ok_reg, io_busy, rx_valid_reg, fd_reg, 1'h0,
		state_reg};

	always_comb begin
		rdata = 32'h0000_0000;
		mapped = 1'h1;
		case (paddr)
			`CAP_OFF_CTRL: rdata = {29'h0, d16_reg, enh_reg, enable_reg};
			`CAP_OFF_ATR_LEN: rdata = {26'h0, atr_len_reg};
			`CAP_OFF_ATR_DATA: rdata = {26'h0, atr_wptr_reg};
			`CAP_OFF_STATUS: rdata = status;
			`CAP_OFF_RX: rdata = {23'h0, rx_valid_reg, rx_hold_reg};
			`CAP_OFF_TX: rdata = {23'h0, tx_pend_reg, tx_hold_reg};
			`CAP_OFF_GLOBAL: rdata = {23'h0, glob_seen_reg,
				clock_stop_indicator_reg, voltage_class_indicator_reg};
			default: mapped = 1'h0;
		endcase
	end

	// Read data is captured in the setup cycle so pready can rise at once.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

//--- verilog/cap_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH
// Summary of operation
// - After a TD announcing T=15, the next TA holds clock stop and class.
// - The card answers a PPS request even when TA1 reads '01'.
// - Default-speed request and response: PPSS, PPS0, PCK.
// - After default PPS: T=0, F=372, D=1, N=0.
// - Enhanced request and response: PPSS, PPS0, PPS1, PCK.
// - After enhanced PPS: T=0, F=512, D=8, N=0.
// - Speed enhancement means F=512 D=8 besides the default pair.
// - Both sides always support F=372 and D=1.
// - The card may also offer F=512 with D=16.
// - Without a PPS exchange the card keeps the default pair.
// - Unsupported request: card answers with a default-value response.
// - Card does error detection and repetition on every character.
// - Guard value 255 means 12 etu between characters.
// - Bit rate is card clock over 372 until a PPS succeeds.
// - Answer to reset holds at most 33 characters.
`define CAP_OFF_CTRL 12'h000
`define CAP_OFF_ATR_LEN 12'h004
`define CAP_OFF_ATR_DATA 12'h008
`define CAP_OFF_STATUS 12'h00C
`define CAP_OFF_RX 12'h010
`define CAP_OFF_TX 12'h014
`define CAP_OFF_GLOBAL 12'h018
`define CAP_CTRL_EN 0
`define CAP_CTRL_ENH 1
`define CAP_CTRL_D16 2
`define CAP_CTRL_RST 3'h0
`define CAP_ST_PPS_OK 8
`define CAP_ST_PPS_BAD 9
`define CAP_ST_TX_FAIL 10
`define CAP_F_DEF 372
`define CAP_F_ENH 512
`define CAP_D_DEF 1
`define CAP_D_ENH 8
`define CAP_D_FAST 16
`define CAP_FI_512 4'h9
`define CAP_DI_8 4'h4
`define CAP_DI_16 4'h5
`define CAP_PPSS 8'hFF
`define CAP_TD_T15 4'hF
`define CAP_ATR_MAX 6'h21
`define CAP_ATR_DELAY 16'h01F4
`define CAP_MAX_REPEAT 3'h4
`define CAP_POS_PARITY 4'h9
`define CAP_POS_GUARD 4'hA
`define CAP_POS_CHECK 4'hB
`define CAP_POS_END 4'hC
`endif

//--- verilog/cap_pkg.sv
// Types shared by the card negotiation block.
`default_nettype none
package cap_pkg;
	typedef enum logic [2:0] {
		ST_RESET, ST_ATR_WAIT, ST_ATR_SEND, ST_LISTEN,
		ST_PPS_RX, ST_PPS_TX, ST_SESSION
	} cap_state_e;
	typedef enum logic [1:0] {FD_DEFAULT, FD_512_8, FD_512_16} cap_fd_e;
	typedef enum logic [1:0] {IO_IDLE, IO_RX, IO_TX} cap_io_e;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} cap_char_s;
endpackage
`default_nettype wire

//--- verilog/cap_etu_gen.sv
// Elementary time unit divider counting card clock rising edges.
`timescale 1ns/1ps
`default_nettype none
module cap_etu_gen (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_rise,
	input wire logic restart,
	input wire logic [8:0] etu_len,
	output logic tick_mid,
	output logic tick_edge
);
	logic [8:0] cnt_reg;
	logic [8:0] last;
	assign last = etu_len - 9'h001;
	assign tick_edge = clk_rise && (cnt_reg == last);
	assign tick_mid = clk_rise && (cnt_reg == ((etu_len >> 1) - 9'h001));
	always_ff @(posedge sys_clk) begin
		if (!rst_b || restart) begin
			cnt_reg <= 9'h000;
		end else if (clk_rise) begin
			cnt_reg <= (cnt_reg == last) ? 9'h000 : cnt_reg + 9'h001;
		end
	end
endmodule
`default_nettype wire

//--- verilog/cap_char_io.sv
// Half-duplex character transceiver with parity error signalling.
`timescale 1ns/1ps
`default_nettype none
module cap_char_io (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic io_in,
	input wire logic tick_mid,
	input wire logic tick_edge,
	input wire cap_pkg::cap_char_s tx_in,
	output logic restart,
	output logic io_oe,
	output cap_pkg::cap_char_s rx_out,
	output logic tx_fail,
	output logic busy
);
	cap_pkg::cap_io_e state_reg;
	logic [3:0] pos_reg;
	logic [8:0] sh_reg;
	logic [2:0] rep_reg;
	logic io_d_reg;
	logic err_reg;
	logic idle;
	logic start_rx;
	assign idle = state_reg == cap_pkg::IO_IDLE;
	assign start_rx = idle && !tx_in.valid && io_d_reg && !io_in;
	assign restart = start_rx || (idle && tx_in.valid);
	assign busy = !idle;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			io_d_reg <= 1'h1;
		end else begin
			io_d_reg <= io_in;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_reg <= cap_pkg::IO_IDLE;
			pos_reg <= 4'h0;
			sh_reg <= 9'h000;
			rep_reg <= 3'h0;
			err_reg <= 1'h0;
			io_oe <= 1'h0;
			rx_out <= '0;
			tx_fail <= 1'h0;
		end else begin
			rx_out.valid <= 1'h0;
			tx_fail <= 1'h0;
			case (state_reg)
				cap_pkg::IO_IDLE: begin
					pos_reg <= 4'h0;
					rep_reg <= 3'h0;
					err_reg <= 1'h0;
					if (tx_in.valid) begin
						sh_reg <= {^tx_in.data, tx_in.data};
						io_oe <= 1'h1;
						state_reg <= cap_pkg::IO_TX;
					end else if (start_rx) begin
						state_reg <= cap_pkg::IO_RX;
					end
				end
				cap_pkg::IO_RX: begin
					if (tick_edge) begin
						pos_reg <= pos_reg + 4'h1;
					end
					if (tick_mid) begin
						if (pos_reg == 4'h0) begin
							if (io_in) begin
								state_reg <= cap_pkg::IO_IDLE;
							end
						end else if (pos_reg <= `CAP_POS_PARITY) begin
							sh_reg <= {io_in, sh_reg[8:1]};
						end else if (pos_reg == `CAP_POS_GUARD) begin
							// A bad parity pulls the line low for one etu.
							if (^sh_reg) begin
								io_oe <= 1'h1;
							end else begin
								rx_out <= {1'h1, sh_reg[7:0]};
								state_reg <= cap_pkg::IO_IDLE;
							end
						end else begin
							io_oe <= 1'h0;
							state_reg <= cap_pkg::IO_IDLE;
						end
					end
				end
				cap_pkg::IO_TX: begin
					if (tick_edge) begin
						pos_reg <= pos_reg + 4'h1;
						if (pos_reg < `CAP_POS_PARITY) begin
							io_oe <= !sh_reg[pos_reg];
						end else if (pos_reg == `CAP_POS_PARITY) begin
							io_oe <= 1'h0;
						end else if (pos_reg == `CAP_POS_GUARD) begin
							err_reg <= !io_in;
						end else if (pos_reg == `CAP_POS_CHECK) begin
							if (!err_reg) begin
								state_reg <= cap_pkg::IO_IDLE;
							end
						end else if (rep_reg == `CAP_MAX_REPEAT) begin
							tx_fail <= 1'h1;
							state_reg <= cap_pkg::IO_IDLE;
						end else begin
							rep_reg <= rep_reg + 3'h1;
							pos_reg <= 4'h0;
							err_reg <= 1'h0;
							io_oe <= 1'h1;
						end
					end
				end
				default: begin
					state_reg <= cap_pkg::IO_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- tb/cap_props.sv
// Port-level checker for the card negotiation block.
`timescale 1ns/1ps
`default_nettype none
module cap_props (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic card_clk,
	input wire logic card_rst_b,
	input wire logic io_in,
	input wire logic io_out,
	input wire logic io_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic en_q, oe_q, ck_q;
	logic [9:0] run;
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			en_q <= 1'b0;
		else if (psel && penable && pready && pwrite && paddr == 12'h000)
			en_q <= pwdata[0];
	end
	// Counts card clock rises since the card last changed its pull on I/O.
	always_ff @(posedge sys_clk) begin
		oe_q <= io_oe;
		ck_q <= card_clk;
		if (!rst_b || io_oe != oe_q)
			run <= 10'h000;
		else if (card_clk && !ck_q && run != 10'h3FF)
			run <= run + 10'h001;
	end
	property p_ready_next;
		psel && !penable |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no pready");
	property p_ready_one;
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready held");
	property p_ready_cause;
		pready |-> psel && penable;
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
	property p_err_unmapped;
		psel && !penable && paddr > 12'h018 |=> pslverr && prdata == 32'h0;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");
	property p_err_ok;
		psel && !penable && paddr == 12'h00C |=> !pslverr;
	endproperty
	a_err_ok: assert property (p_err_ok) else $error("false pslverr");
	property p_rdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not 0");
	property p_ctrl_read;
		psel && !penable && !pwrite && paddr == 12'h000 |=> prdata[0] == en_q;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl readback");
	property p_open_drain;
		io_out == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("io_out high");
	property p_quiet_off;
		(!card_rst_b || !en_q) [*3] |-> !io_oe;
	endproperty
	a_quiet_off: assert property (p_quiet_off) else $error("io while off");
	property p_bit_min;
		card_rst_b && en_q && io_oe != oe_q |-> run >= 10'h01E;
	endproperty
	a_bit_min: assert property (p_bit_min) else $error("short bit");
	c_err: cover property (pslverr);
	c_oe: cover property ($rose(io_oe));
	c_wr: cover property (pready && pwrite);
endmodule
bind cap_top cap_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.card_clk(card_clk), .card_rst_b(card_rst_b), .io_in(io_in),
	.io_out(io_out), .io_oe(io_oe));
`default_nettype wire

//--- tb/cap_term_model.sv
// Terminal model: card clock, pulled-up I/O line, serial characters.
`timescale 1ns/1ps
`default_nettype none
module cap_term_model (
	input wire logic card_oe,
	output logic card_clk,
	output logic io_wire,
	output logic got_stb,
	output logic [7:0] got_byte,
	output logic got_perr
);
	logic pull = 1'b0;
	logic busy = 1'b0;
	logic nack = 1'b0;
	logic [8:0] sh;
	int e = 372;
	assign io_wire = ~(card_oe | pull);
	initial begin
		card_clk = 1'b0;
		// Edges fall between system clock edges, so sampling is race free.
		#0.25;
		forever #10.5 card_clk = ~card_clk;
	end
	initial begin
		got_stb = 1'b0;
		got_byte = 8'h00;
		got_perr = 1'b0;
	end
	task automatic etu(input int n);
		repeat (n) @(posedge card_clk);
	endtask
	// Start bit, data LSB first, even parity, then two guard etu.
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {^c, c, 1'b0};
		busy = 1'b1;
		for (int i = 0; i < 10; i++) begin
			pull = ~f[i];
			etu(e);
		end
		pull = 1'b0;
		// The card may answer during the guard time, so listen again now.
		busy = 1'b0;
		etu(2 * e);
	endtask
	always begin
		@(negedge io_wire);
		if (!busy) begin
			etu(e / 2);
			for (int i = 0; i < 9; i++) begin
				etu(e);
				sh[i] = io_wire;
			end
			if (nack) begin
				etu(e);
				pull = 1'b1;
				etu(e);
				pull = 1'b0;
				nack = 1'b0;
			end else begin
				got_byte = sh[7:0];
				got_perr = ^sh;
				got_stb = 1'b1;
				etu(1);
				got_stb = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/cap_top_tb.sv
// Self-checking bench for the card negotiation block.
`timescale 1ns/1ps
`default_nettype none
module cap_top_tb;
	logic sys_clk, rst_b, psel, penable, pwrite, card_rst_b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, io_out, io_oe, card_clk, io_wire;
	logic got_stb, got_perr;
	logic [7:0] got_byte, ta, sd;
	logic [2:0] ctl;
	logic [1:0] fd;
	logic acc;
	logic [7:0] atr [3];
	logic [7:0] req [4];
	logic [64:0] rv;
	logic [64:0] rq [$];
	logic [7:0] cq [$];
	int bad_count, num_checks, got_n;
	cap_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .card_clk(card_clk), .card_rst_b(card_rst_b),
		.io_in(io_wire), .io_out(io_out), .io_oe(io_oe));
	cap_term_model term (.card_oe(io_oe), .card_clk(card_clk),
		.io_wire(io_wire), .got_stb(got_stb), .got_byte(got_byte),
		.got_perr(got_perr));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task results;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk_reg(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task chk_chr(input logic [7:0] e, input logic [7:0] g, input logic p);
		num_checks++;
		if (g !== e || p !== 1'b0) begin
			bad_count++;
			$display("Error char expected %h seen %h", e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			results;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic err);
		rq.push_back({err, m, e});
		apb(1'b0, a, 32'h0);
	endtask
	task wait_got(input int n);
		int k;
		k = 0;
		while (got_n < n) begin
			@(posedge sys_clk);
			k++;
			if (k > 60000) begin
				bad_count++;
				results;
			end
		end
	endtask
	always @(posedge sys_clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
			pwrite === 1'b0) begin
			rv = rq.pop_front();
			chk_reg("prdata", rv[31:0], prdata & rv[63:32]);
			chk_reg("pslverr", {31'h0, rv[64]}, {31'h0, pslverr});
		end
	end
	always @(posedge got_stb) begin
		got_n++;
		chk_chr(cq.pop_front(), got_byte, got_perr);
	end
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rst_b = 1'b0;
		card_rst_b = 1'b0;
		bad_count = 0;
		num_checks = 0;
		got_n = 0;
		void'($urandom(32'h39e381f8));
		ta = ($urandom % 2) ? 8'h95 : 8'h94;
		ctl = {1'($urandom % 2), 2'h3};
		sd = 8'($urandom);
		acc = (ta == 8'h94) || ctl[2];
		fd = acc ? (ta[0] ? 2'h2 : 2'h1) : 2'h0;
		atr = '{8'h3B, 8'h10, ta};
		req = '{8'hFF, 8'h10, ta, 8'hFF ^ 8'h10 ^ ta};
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(12'h000, 32'h0, 32'hFFFFFFFF, 1'b0);
		rd(12'h100, 32'h0, 32'hFFFFFFFF, 1'b1);
		rd(12'h00C, 32'h0, 32'h7, 1'b0);
		apb(1'b1, 12'h004, 32'h3);
		foreach (atr[i]) begin
			apb(1'b1, 12'h008, {24'h0, atr[i]});
			cq.push_back(atr[i]);
		end
		rd(12'h008, 32'h3, 32'h3F, 1'b0);
		term.nack = 1'b1;
		apb(1'b1, 12'h000, {29'h0, ctl});
		card_rst_b <= 1'b1;
		wait_got(3);
		term.etu(1116);
		rd(12'h00C, {7'h0, 1'b1, ta, 16'h3}, 32'h1FF0207, 1'b0);
		rd(12'h018, 32'h0, 32'h1FF, 1'b0);
		cq.push_back(8'hFF);
		if (acc) begin
			cq.push_back(8'h10);
			cq.push_back(ta);
		end else begin
			cq.push_back(8'h00);
		end
		cq.push_back(acc ? 8'hFF ^ 8'h10 ^ ta : 8'hFF);
		foreach (req[i])
			term.send(req[i]);
		wait_got(acc ? 7 : 6);
		term.etu(1116);
		rd(12'h00C, {23'h0, 1'b1, 2'h0, fd, 4'h6}, 32'h337, 1'b0);
		term.e = acc ? (ta[0] ? 512 / 16 : 512 / 8) : 372;
		cq.push_back(sd);
		apb(1'b1, 12'h014, {24'h0, sd});
		wait_got(acc ? 8 : 7);
		results;
	end
endmodule
`default_nettype wire
